// ==== feq_err_fifo.sv ====
`timescale 1ns/100ps
module feq_err_fifo (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic push_in,
   input wire feq_pkg::feq_err_t push_id_in,
   input wire logic pop_in,
   input wire logic clear_in,
   output feq_pkg::feq_err_t head_id_out,
   output logic [feq_pkg::CNT_W-1:0] count_out
);
   import feq_pkg::*;

   feq_err_t mem [Q_DEPTH];
   logic [CNT_W-1:0] rd_r;
   logic [CNT_W-1:0] wr_r;
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] after_pop;
   logic do_pop;
   logic do_push;
   feq_err_t wr_id;

   function automatic logic [CNT_W-1:0] next_ptr(
      input logic [CNT_W-1:0] p);
      return (p == Q_LAST) ? '0 : p + 5'h01;
   endfunction

   always_comb begin
      do_pop = pop_in && !clear_in && (count_r != '0);
      after_pop = clear_in ? '0 : count_r - {4'h0, do_pop};
      // Clear and a new error in one cycle: the error survives
      do_push = push_in && (after_pop != Q_FULL);
      wr_id = (after_pop == Q_LAST) ? ERR_OVERFLOW : push_id_in;
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rd_r <= '0;
      end else if (clear_in) begin
         rd_r <= wr_r;
      end else if (do_pop) begin
         rd_r <= next_ptr(rd_r);
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_r <= '0;
      end else if (do_push) begin
         wr_r <= next_ptr(wr_r);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (do_push) begin
         mem[wr_r] <= wr_id;
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         count_r <= '0;
      end else begin
         count_r <= after_pop + {4'h0, do_push};
      end
   end

   // Oldest record always sits at the read pointer
   assign head_id_out = mem[rd_r];
   assign count_out = count_r;
endmodule

// ==== feq_host_model.sv ====
`timescale 1ns/100ps
module feq_host_model (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_data_in,
   input wire logic slow_in,
   output logic tx_ready_out
);
   logic [7:0] rx_q[$];
   logic [1:0] ph_r = 2'h0;
   logic rdy_r = 1'b0;
   assign tx_ready_out = rdy_r;
   // Slow host takes one byte in four
   always @(negedge clk_sys_in) begin
      ph_r <= ph_r + 2'h1;
      rdy_r <= resetn_in && (!slow_in || ph_r == 2'h0);
   end
   always @(posedge clk_sys_in) begin
      if (resetn_in && tx_valid_in && rdy_r) begin
         rx_q.push_back(tx_data_in);
      end
   end
endmodule

// ==== feq_monitor.sv ====
`timescale 1ns/100ps
module feq_monitor
   import feq_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic cmd_valid_in,
   input wire feq_pkg::feq_cmd_t cmd_code_in,
   input wire logic cmd_bcast_in,
   input wire logic cmd_ready_out,
   input wire logic tx_valid_out,
   input wire logic [7:0] tx_data_out,
   input wire logic tx_ready_in,
   input wire logic nv_ind_out,
   input wire logic nv_save_out,
   input wire logic st_fault_in,
   input wire logic st_no_laser_in,
   input wire logic st_fw_update_in,
   input wire logic led_red_out,
   input wire logic led_green_out,
   input wire logic led_blue_out,
   input wire logic sub_start_in,
   input wire logic sub_send_out,
   input wire logic sub_busy_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   logic acc;
   logic [2:0] led;
   assign acc = cmd_valid_in && cmd_ready_out;
   assign led = {led_red_out, led_green_out, led_blue_out};
   chk_tx_stands:
      assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out &&
         $stable(tx_data_out)) else $error("reply byte not held");
   // Top digit of a fault word can never exceed 7
   chk_fault_digit:
      assert property (acc && !cmd_bcast_in && cmd_code_in == CMD_FAULT_Q
         |=> !cmd_ready_out ##[0:1] tx_valid_out &&
         tx_data_out inside {[CH_ZERO:8'h37]})
      else $error("bad first fault digit");
   chk_clear_quiet:
      assert property (acc && cmd_code_in == CMD_ERR_CLEAR
         |=> cmd_ready_out && !tx_valid_out)
      else $error("clear produced a reply");
   chk_bcast_quiet:
      assert property (acc && cmd_bcast_in && cmd_code_in == CMD_FAULT_Q
         |=> cmd_ready_out && !tx_valid_out ##1 !tx_valid_out)
      else $error("broadcast query answered");
   chk_ind_save:
      assert property (acc && !cmd_bcast_in && cmd_code_in == CMD_IND_SET
         |=> ##[0:1] nv_save_out) else $error("setting not saved");
   chk_led_off:
      assert property (!nv_ind_out [*2] |-> led == LED_OFF)
      else $error("lamp lit while disabled");
   chk_led_red:
      assert property (nv_ind_out && st_fault_in && !st_no_laser_in &&
         !st_fw_update_in |=> led == LED_RED) else $error("lamp not red");
   chk_led_yellow:
      assert property (nv_ind_out && st_no_laser_in && !st_fw_update_in
         |=> led == LED_YELLOW) else $error("lamp not yellow");
   chk_sub_send:
      assert property (sub_start_in && !sub_busy_out |=> sub_send_out
         ##1 !sub_send_out) else $error("no single send pulse");
   cover property (acc && cmd_code_in == CMD_ERR_ALL_Q);
   cover property (tx_valid_out && !tx_ready_in);
   cover property (sub_busy_out ##1 !sub_busy_out);
endmodule

bind feq_top feq_monitor u_feq_monitor (.*);

// ==== feq_pkg.sv ====
package feq_pkg;
   localparam int Q_DEPTH = 20;
   localparam int CNT_W = 5;
   localparam int ARG_W = 8;
   localparam int WORD_W = 32;
   localparam int REC_CHARS = 40;
   localparam int POS_W = 6;
   localparam logic [CNT_W-1:0] Q_FULL = 5'h14;
   localparam logic [CNT_W-1:0] Q_LAST = 5'h13;
   localparam logic [CNT_W-1:0] CNT_TEN = 5'h0A;
   localparam logic [CNT_W-1:0] CNT_TWENTY = 5'h14;
   localparam logic [WORD_W-1:0] FAULT_MASK = 32'h7FFF_FFFF;
   localparam int MSB_BIT = 31;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_HEX_OFS = 8'h37;
   localparam logic [7:0] CH_O = 8'h4F;
   localparam logic [7:0] CH_N = 8'h4E;
   localparam logic [7:0] CH_F = 8'h46;
   localparam logic IND_DEFAULT = 1'b1;
   localparam logic [2:0] LED_OFF = 3'h0;
   localparam logic [2:0] LED_WHITE = 3'h7;
   localparam logic [2:0] LED_BLUE = 3'h1;
   localparam logic [2:0] LED_GREEN = 3'h2;
   localparam logic [2:0] LED_RED = 3'h4;
   localparam logic [2:0] LED_YELLOW = 3'h6;
   localparam int CLK_MHZ = 250;
   localparam int SUB_TIMEOUT_MS = 700;
   localparam int SUB_TIMEOUT_CYC = SUB_TIMEOUT_MS * CLK_MHZ * 1000;
   localparam logic [1:0] SUB_RETRIES = 2'h3;
   localparam int BLINK_MS = 500;
   localparam int BLINK_CYC = BLINK_MS * CLK_MHZ * 1000;

   typedef enum logic [3:0] {
      CMD_FAULT_Q, CMD_STATUS_Q, CMD_IND_SET, CMD_IND_Q,
      CMD_ERR_COUNT_Q, CMD_ERR_NEXT_Q, CMD_ERR_ALL_Q, CMD_ERR_CLEAR,
      CMD_UNKNOWN
   } feq_cmd_t;

   typedef enum logic [4:0] {
      ERR_QUERY_UNAVAIL, ERR_OVERFLOW, ERR_NO_MEMORY, ERR_SYSTEM,
      ERR_NO_FILE_NAME, ERR_NO_FILE, ERR_DEV_UNAVAIL, ERR_SETTINGS,
      ERR_INVALID_PARAM, ERR_PROTECTED, ERR_EXECUTION, ERR_PARAM_MISSING,
      ERR_SYNTAX, ERR_UNRECOGNIZED, ERR_NONE, ERR_I2C, ERR_TIMEOUT,
      ERR_CALIBRATION
   } feq_err_t;
endpackage

// ==== feq_top.sv ====
`timescale 1ns/100ps
module feq_top #(
   parameter int unsigned SUB_TIMEOUT = feq_pkg::SUB_TIMEOUT_CYC,
   parameter int unsigned BLINK_HALF = feq_pkg::BLINK_CYC
) (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic cmd_valid_in,
   input wire feq_pkg::feq_cmd_t cmd_code_in,
   input wire logic cmd_bcast_in,
   input wire logic cmd_onoff_in,
   input wire logic [feq_pkg::ARG_W-1:0] cmd_count_in,
   output logic cmd_ready_out,
   input wire logic err_valid_in,
   input wire feq_pkg::feq_err_t err_id_in,
   input wire logic err_ext_in,
   output logic err_ready_out,
   input wire logic [feq_pkg::WORD_W-1:0] fault_word_in,
   input wire logic [feq_pkg::WORD_W-1:0] status_word_in,
   input wire logic is_controller_in,
   output logic tx_valid_out,
   output logic [7:0] tx_data_out,
   input wire logic tx_ready_in,
   input wire logic nv_ind_in,
   output logic nv_save_out,
   output logic nv_ind_out,
   input wire logic st_emission_in,
   input wire logic st_standby_in,
   input wire logic st_warmup_in,
   input wire logic st_warmup_blink_in,
   input wire logic st_fault_in,
   input wire logic st_no_laser_in,
   input wire logic st_fw_update_in,
   output logic led_red_out,
   output logic led_green_out,
   output logic led_blue_out,
   input wire logic sub_start_in,
   input wire logic sub_resp_in,
   output logic sub_send_out,
   output logic sub_busy_out
);
   import feq_pkg::*;

   typedef enum logic [2:0] {
      RS_IDLE, RS_HEX, RS_DEC, RS_ONOFF, RS_REC, RS_CR, RS_LF
   } feq_rs_t;

   feq_rs_t rs_r;
   logic [POS_W-1:0] pos_r;
   logic [WORD_W-1:0] word_r;
   logic [CNT_W-1:0] cnt_snap_r;
   logic [ARG_W-1:0] recs_r;
   logic rec_mode_r;
   logic ready_r;
   logic tx_valid_r;
   logic [7:0] tx_data_r;
   logic ind_r;
   logic loaded_r;
   logic nv_save_r;
   logic hold_v_r;
   feq_err_t hold_id_r;
   logic err_ready_r;
   logic tmo_pend_r;
   logic sub_busy_r;
   logic sub_send_r;
   logic [1:0] tries_r;
   logic [31:0] timer_r;
   logic [31:0] blink_cnt_r;
   logic blink_r;
   logic [2:0] led_r;

   feq_err_t head_id;
   logic [CNT_W-1:0] q_count;
   logic accept;
   logic is_q;
   logic cmd_err;
   feq_err_t cmd_err_id;
   logic tmo_take;
   logic hold_take;
   logic q_push;
   feq_err_t q_push_id;
   logic q_pop;
   logic q_clear;
   logic adv;
   logic last;
   logic [7:0] cur_char;
   logic [POS_W-1:0] body_len;
   logic [8*REC_CHARS-1:0] rec_s;
   logic [CNT_W-1:0] tens;
   logic [CNT_W-1:0] ones;
   logic [2:0] colour;
   logic sub_expire;

   function automatic logic is_query(input feq_cmd_t c);
      return c inside {CMD_FAULT_Q, CMD_STATUS_Q, CMD_IND_Q,
                       CMD_ERR_COUNT_Q, CMD_ERR_NEXT_Q, CMD_ERR_ALL_Q};
   endfunction

   function automatic logic [7:0] hex_char(input logic [3:0] n);
      return (n < 4'hA) ? CH_ZERO + {4'h0, n} : CH_HEX_OFS + {4'h0, n};
   endfunction

   // Strings are right-justified; leading bytes stay zero
   function automatic logic [8*REC_CHARS-1:0] rec_str(input feq_err_t id);
      logic [8*REC_CHARS-1:0] s;
      s = '0;
      case (id)
         ERR_QUERY_UNAVAIL: s = "-400,\"Query Unavailable\"";
         ERR_OVERFLOW: s = "-350,\"Queue overflow\"";
         ERR_NO_MEMORY: s = "-321,\"Out of memory\"";
         ERR_SYSTEM: s = "-310,\"System error\"";
         ERR_NO_FILE_NAME: s = "-257,\"File to open not named\"";
         ERR_NO_FILE: s = "-256,\"File does not exist\"";
         ERR_DEV_UNAVAIL: s = "-241,\"Device Unavailable\"";
         ERR_SETTINGS: s = "-221,\"Settings conflict\"";
         ERR_INVALID_PARAM: s = "-220,\"Invalid parameter\"";
         ERR_PROTECTED: s = "-203,\"Command protected\"";
         ERR_EXECUTION: s = "-200,\"Execution error\"";
         ERR_PARAM_MISSING: s = "-109,\"Parameter missing\"";
         ERR_SYNTAX: s = "-102,\"Syntax error\"";
         ERR_UNRECOGNIZED: s = "-100,\"Unrecognized command or query\"";
         ERR_NONE: s = "0,\"No error\"";
         ERR_I2C: s = "510,\"I2C bus fault\"";
         ERR_TIMEOUT: s = "520,\"Controller Timed Out\"";
         ERR_CALIBRATION: s = "600,\"Laser calibration fault\"";
         default: s = "0,\"No error\"";
      endcase
      return s;
   endfunction

   function automatic logic [POS_W-1:0] str_len(
      input logic [8*REC_CHARS-1:0] s);
      logic [POS_W-1:0] n;
      n = '0;
      for (int i = 0; i < REC_CHARS; i++) begin
         if (s[8*i +: 8] != 8'h00) begin
            n = POS_W'(i + 1);
         end
      end
      return n;
   endfunction

   feq_err_fifo u_queue (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .push_in(q_push),
      .push_id_in(q_push_id),
      .pop_in(q_pop),
      .clear_in(q_clear),
      .head_id_out(head_id),
      .count_out(q_count)
   );

   always_comb begin
      accept = (rs_r == RS_IDLE) && cmd_valid_in && ready_r;
      is_q = is_query(cmd_code_in);
      cmd_err = accept && ((is_q && cmd_bcast_in) ||
                           (cmd_code_in == CMD_UNKNOWN));
      cmd_err_id = (is_q && cmd_bcast_in) ? ERR_QUERY_UNAVAIL
                                          : ERR_UNRECOGNIZED;
      tmo_take = tmo_pend_r && !cmd_err;
      hold_take = hold_v_r && !cmd_err && !tmo_pend_r;
      q_push = cmd_err || tmo_pend_r || hold_v_r;
      q_push_id = cmd_err ? cmd_err_id : (tmo_pend_r ? ERR_TIMEOUT
                                                       : hold_id_r);
      q_clear = accept && (cmd_code_in == CMD_ERR_CLEAR);
      adv = (rs_r != RS_IDLE) && (!tx_valid_r || tx_ready_in);
      q_pop = adv && (rs_r == RS_LF) && rec_mode_r;
   end

   always_comb begin
      rec_s = rec_str(head_id);
      tens = (cnt_snap_r >= CNT_TWENTY) ? 5'h02 :
             ((cnt_snap_r >= CNT_TEN) ? 5'h01 : 5'h00);
      ones = cnt_snap_r - ((tens == 5'h02) ? CNT_TWENTY :
                           ((tens == 5'h01) ? CNT_TEN : 5'h00));
      cur_char = CH_CR;
      body_len = 6'h01;
      case (rs_r)
         RS_HEX: begin
            cur_char = hex_char(word_r[WORD_W-1 -: 4]);
            body_len = 6'h08;
         end
         RS_DEC: begin
            body_len = (tens != '0) ? 6'h02 : 6'h01;
            cur_char = (tens != '0 && pos_r == '0) ?
                       CH_ZERO + {3'h0, tens} : CH_ZERO + {3'h0, ones};
         end
         RS_ONOFF: begin
            body_len = ind_r ? 6'h02 : 6'h03;
            cur_char = (pos_r == '0) ? CH_O : (ind_r ? CH_N : CH_F);
         end
         RS_REC: begin
            body_len = str_len(rec_s);
            cur_char = rec_s[8*(int'(body_len) - 1 - int'(pos_r)) +: 8];
         end
         RS_LF: cur_char = CH_LF;
         default: cur_char = CH_CR;
      endcase
      last = (pos_r == body_len - 6'h01);
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rs_r <= RS_IDLE;
         pos_r <= '0;
         word_r <= '0;
         cnt_snap_r <= '0;
         recs_r <= '0;
         rec_mode_r <= 1'b0;
         ready_r <= 1'b1;
      end else if (accept) begin
         pos_r <= '0;
         rec_mode_r <= 1'b0;
         if (!(is_q && cmd_bcast_in)) begin
            case (cmd_code_in)
               CMD_FAULT_Q: begin
                  word_r <= fault_word_in & FAULT_MASK;
                  rs_r <= RS_HEX;
                  ready_r <= 1'b0;
               end
               CMD_STATUS_Q: begin
                  word_r <= {is_controller_in,
                             status_word_in[MSB_BIT-1:0]};
                  rs_r <= RS_HEX;
                  ready_r <= 1'b0;
               end
               CMD_IND_Q: begin
                  rs_r <= RS_ONOFF;
                  ready_r <= 1'b0;
               end
               CMD_ERR_COUNT_Q: begin
                  cnt_snap_r <= q_count;
                  rs_r <= RS_DEC;
                  ready_r <= 1'b0;
               end
               CMD_ERR_NEXT_Q, CMD_ERR_ALL_Q: begin
                  if (q_count != '0) begin
                     rec_mode_r <= 1'b1;
                     rs_r <= RS_REC;
                     ready_r <= 1'b0;
                     if (cmd_code_in == CMD_ERR_ALL_Q) begin
                        recs_r <= {3'h0, q_count};
                     end else begin
                        recs_r <= (cmd_count_in == '0) ? 8'h01
                                                       : cmd_count_in;
                     end
                  end
               end
               default: rs_r <= RS_IDLE;
            endcase
         end
      end else if (adv) begin
         case (rs_r)
            RS_HEX, RS_DEC, RS_ONOFF, RS_REC: begin
               if (rs_r == RS_HEX) begin
                  word_r <= {word_r[WORD_W-5:0], 4'h0};
               end
               if (last) begin
                  rs_r <= RS_CR;
                  pos_r <= '0;
               end else begin
                  pos_r <= pos_r + 6'h01;
               end
            end
            RS_CR: rs_r <= RS_LF;
            RS_LF: begin
               // Stop early if the queue runs dry before the count
               if (rec_mode_r && recs_r > 8'h01 && q_count > 5'h01) begin
                  recs_r <= recs_r - 8'h01;
                  rs_r <= RS_REC;
               end else begin
                  rs_r <= RS_IDLE;
                  ready_r <= 1'b1;
               end
            end
            default: rs_r <= RS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_valid_r <= 1'b0;
         tx_data_r <= 8'h00;
      end else if (adv) begin
         tx_valid_r <= 1'b1;
         tx_data_r <= cur_char;
      end else if (tx_ready_in) begin
         tx_valid_r <= 1'b0;
      end
   end

   // One-deep holding slot: command errors may win the queue port
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         hold_v_r <= 1'b0;
         hold_id_r <= ERR_NONE;
         err_ready_r <= 1'b0;
      end else begin
         if (err_valid_in && err_ready_r && err_ext_in) begin
            hold_v_r <= 1'b1;
            hold_id_r <= err_id_in;
            err_ready_r <= 1'b0;
         end else if (hold_take || !hold_v_r) begin
            hold_v_r <= 1'b0;
            err_ready_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ind_r <= IND_DEFAULT;
         loaded_r <= 1'b0;
         nv_save_r <= 1'b0;
      end else begin
         nv_save_r <= 1'b0;
         if (!loaded_r) begin
            ind_r <= nv_ind_in;
            loaded_r <= 1'b1;
         end else if (accept && cmd_code_in == CMD_IND_SET) begin
            ind_r <= cmd_onoff_in;
            nv_save_r <= 1'b1;
         end
      end
   end

   always_comb begin
      sub_expire = sub_busy_r && !sub_resp_in &&
                   (timer_r == SUB_TIMEOUT - 1);
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sub_busy_r <= 1'b0;
         sub_send_r <= 1'b0;
         tries_r <= '0;
         timer_r <= '0;
      end else begin
         sub_send_r <= 1'b0;
         if (!sub_busy_r) begin
            if (sub_start_in) begin
               sub_busy_r <= 1'b1;
               sub_send_r <= 1'b1;
               tries_r <= '0;
               timer_r <= '0;
            end
         end else if (sub_resp_in) begin
            sub_busy_r <= 1'b0;
         end else if (sub_expire) begin
            timer_r <= '0;
            if (tries_r == SUB_RETRIES) begin
               sub_busy_r <= 1'b0;
            end else begin
               tries_r <= tries_r + 2'h1;
               sub_send_r <= 1'b1;
            end
         end else begin
            timer_r <= timer_r + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tmo_pend_r <= 1'b0;
      end else if (sub_expire && tries_r == SUB_RETRIES) begin
         tmo_pend_r <= 1'b1;
      end else if (tmo_take) begin
         tmo_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         blink_cnt_r <= '0;
         blink_r <= 1'b0;
      end else if (blink_cnt_r == BLINK_HALF - 1) begin
         blink_cnt_r <= '0;
         blink_r <= !blink_r;
      end else begin
         blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
      end
   end

   always_comb begin
      if (st_fw_update_in) begin
         colour = blink_r ? LED_YELLOW : LED_OFF;
      end else if (st_no_laser_in) begin
         colour = LED_YELLOW;
      end else if (st_fault_in) begin
         colour = LED_RED;
      end else if (st_emission_in) begin
         colour = LED_WHITE;
      end else if (st_warmup_in) begin
         colour = (st_warmup_blink_in && !blink_r) ? LED_OFF : LED_GREEN;
      end else if (st_standby_in) begin
         colour = LED_BLUE;
      end else begin
         colour = LED_OFF;
      end
   end

   // Lamp only; status word path never sees the enable
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         led_r <= LED_OFF;
      end else begin
         led_r <= ind_r ? colour : LED_OFF;
      end
   end

   assign cmd_ready_out = ready_r;
   assign err_ready_out = err_ready_r;
   assign tx_valid_out = tx_valid_r;
   assign tx_data_out = tx_data_r;
   assign nv_save_out = nv_save_r;
   assign nv_ind_out = ind_r;
   assign led_red_out = led_r[2];
   assign led_green_out = led_r[1];
   assign led_blue_out = led_r[0];
   assign sub_send_out = sub_send_r;
   assign sub_busy_out = sub_busy_r;
endmodule

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
   import feq_pkg::*;
   logic clk_sys_in = 1'b0, resetn_in = 1'b0, cmd_valid_in = 1'b0;
   feq_cmd_t cmd_code_in = CMD_FAULT_Q;
   logic cmd_bcast_in = 1'b0, cmd_onoff_in = 1'b0, err_valid_in = 1'b0;
   logic [7:0] cmd_count_in = 8'h00;
   feq_err_t err_id_in = ERR_NONE;
   logic err_ext_in = 1'b1, is_controller_in = 1'b0, nv_ind_in = 1'b1;
   logic [31:0] fault_word_in = 32'h0000_0000, status_word_in = 32'h0000_0000;
   logic st_emission_in = 1'b0, st_standby_in = 1'b1, st_warmup_in = 1'b1;
   logic st_warmup_blink_in = 1'b0, st_fault_in = 1'b0, slow = 1'b0;
   logic st_no_laser_in = 1'b0, st_fw_update_in = 1'b0;
   logic sub_start_in = 1'b0, sub_resp_in = 1'b0;
   logic cmd_ready_out, err_ready_out, tx_valid_out, tx_ready_in;
   logic nv_save_out, nv_ind_out, led_red_out, led_green_out;
   logic led_blue_out, sub_send_out, sub_busy_out;
   logic [7:0] tx_data_out;
   logic [7:0] leds;
   int err_count = 0;
   int n_compared = 0;
   assign leds = {5'h00, led_red_out, led_green_out, led_blue_out};
   always #2 clk_sys_in = ~clk_sys_in;
   feq_top #(.SUB_TIMEOUT(20), .BLINK_HALF(4)) u_feq_top (.*);
   feq_host_model u_feq_host_model (.clk_sys_in, .resetn_in,
      .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out), .slow_in(slow),
      .tx_ready_out(tx_ready_in));
   task automatic bad(input string m);
      err_count++;
      $display("ERROR %0t: %s", $time, m);
   endtask
   task automatic eq(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) bad($sformatf("value %h want %h", got, exp));
   endtask
   task automatic cmd(input feq_cmd_t c, input logic [7:0] n = 8'h00,
         input logic b = 1'b0);
      @(negedge clk_sys_in);
      repeat (400) if (cmd_ready_out !== 1'b1) @(negedge clk_sys_in);
      cmd_code_in = c;
      cmd_count_in = n;
      cmd_bcast_in = b;
      cmd_valid_in = 1'b1;
      @(negedge clk_sys_in);
      cmd_valid_in = 1'b0;
      repeat (5000) if (cmd_ready_out !== 1'b1 || tx_valid_out !== 1'b0)
         @(negedge clk_sys_in);
      if (cmd_ready_out !== 1'b1) bad("command hung");
      repeat (3) @(negedge clk_sys_in);
   endtask
   task automatic push(input feq_err_t e, input logic x);
      repeat (50) if (err_ready_out !== 1'b1) @(negedge clk_sys_in);
      err_id_in = e;
      err_ext_in = x;
      err_valid_in = 1'b1;
      @(negedge clk_sys_in);
      err_valid_in = 1'b0;
      @(negedge clk_sys_in);
   endtask
   // Whole line must match; a record only by its code
   task automatic chk(input string exp, input bit rec = 1'b0);
      string s, b;
      int l;
      bit ok;
      while (u_feq_host_model.rx_q.size() > 0 && s.len() < 60) begin
         s = {s, string'(u_feq_host_model.rx_q.pop_front())};
         if (s[s.len()-1] == 8'h0A) break;
      end
      l = s.len();
      n_compared++;
      ok = l > 2 && s[l-2] == 8'h0D && s[l-1] == 8'h0A;
      b = s.substr(0, l - 3);
      if (rec)
         ok = ok && b[l-3] == 8'h22 && b.substr(0, exp.len() + 1) ==
            {exp, ",\""};
      else
         ok = ok && b == exp;
      if (!ok) bad({"reply ", b, " want ", exp});
   endtask
   task automatic none();
      n_compared++;
      if (u_feq_host_model.rx_q.size() != 0) bad("unexpected reply");
   endtask
   task automatic t_fault();
      fault_word_in = 32'hFEDC_BA98;
      status_word_in = 32'h8000_0012;
      slow = 1'b1;
      cmd(CMD_FAULT_Q);
      chk("7EDCBA98");
      is_controller_in = 1'b1;
      cmd(CMD_STATUS_Q);
      chk("80000012");
      is_controller_in = 1'b0;
      cmd(CMD_STATUS_Q);
      chk("00000012");
      slow = 1'b0;
      $display("fault test done");
   endtask
   task automatic t_ind();
      st_fault_in = 1'b1;
      cmd_onoff_in = 1'b0;
      cmd(CMD_IND_SET);
      eq({7'h00, nv_ind_out}, 8'h00);
      eq(leds, 8'h00);
      cmd(CMD_IND_Q);
      chk("OFF");
      cmd(CMD_STATUS_Q);
      chk("00000012");
      cmd_onoff_in = 1'b1;
      cmd(CMD_IND_SET);
      cmd(CMD_IND_Q);
      chk("ON");
      eq(leds, {5'h00, LED_RED});
      st_no_laser_in = 1'b1;
      repeat (2) @(negedge clk_sys_in);
      eq(leds, {5'h00, LED_YELLOW});
      st_no_laser_in = 1'b0;
      st_fault_in = 1'b0;
      st_emission_in = 1'b1;
      repeat (2) @(negedge clk_sys_in);
      eq(leds, {5'h00, LED_WHITE});
      st_emission_in = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      eq(leds, {5'h00, LED_GREEN});
      st_warmup_in = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      eq(leds, {5'h00, LED_BLUE});
      $display("indicator test done");
   endtask
   task automatic t_codes();
      feq_err_t ids[9] = '{ERR_UNRECOGNIZED, ERR_SYNTAX, ERR_PARAM_MISSING,
         ERR_INVALID_PARAM, ERR_SETTINGS, ERR_PROTECTED, ERR_EXECUTION,
         ERR_DEV_UNAVAIL, ERR_QUERY_UNAVAIL};
      string txt[9] = '{"-100", "-102", "-109", "-220", "-221", "-203",
         "-200", "-241", "-400"};
      foreach (ids[i]) push(ids[i], 1'b1);
      cmd(CMD_ERR_COUNT_Q);
      chk("9");
      slow = 1'b1;
      cmd(CMD_ERR_ALL_Q);
      foreach (txt[i]) chk(txt[i], 1'b1);
      slow = 1'b0;
      cmd(CMD_ERR_COUNT_Q);
      chk("0");
      $display("codes test done");
   endtask
   task automatic t_over();
      repeat (22) push(ERR_SYNTAX, 1'b1);
      cmd(CMD_ERR_COUNT_Q);
      chk("20");
      cmd(CMD_ERR_NEXT_Q);
      chk("-102", 1'b1);
      cmd(CMD_ERR_COUNT_Q);
      chk("19");
      cmd(CMD_ERR_NEXT_Q, 8'h13);
      repeat (18) chk("-102", 1'b1);
      chk("-350", 1'b1);
      cmd(CMD_ERR_NEXT_Q);
      none();
      cmd(CMD_ERR_ALL_Q);
      none();
      $display("overflow test done");
   endtask
   task automatic t_clear();
      push(ERR_PARAM_MISSING, 1'b1);
      push(ERR_INVALID_PARAM, 1'b1);
      push(ERR_I2C, 1'b0);
      cmd(CMD_ERR_COUNT_Q);
      chk("2");
      cmd(CMD_ERR_NEXT_Q);
      chk("-109", 1'b1);
      cmd(CMD_ERR_NEXT_Q);
      chk("-220", 1'b1);
      push(ERR_SYNTAX, 1'b1);
      cmd(CMD_ERR_CLEAR);
      none();
      cmd(CMD_ERR_COUNT_Q);
      chk("0");
      cmd(CMD_FAULT_Q, 8'h00, 1'b1);
      none();
      cmd(CMD_UNKNOWN);
      cmd(CMD_ERR_ALL_Q);
      chk("-400", 1'b1);
      chk("-100", 1'b1);
      $display("clear test done");
   endtask
   task automatic t_sub();
      int sends = 0;
      sub_start_in = 1'b1;
      repeat (200) begin
         @(negedge clk_sys_in);
         sub_start_in = 1'b0;
         if (sub_send_out === 1'b1) sends++;
      end
      eq(8'(sends), 8'h04);
      eq({7'h00, sub_busy_out}, 8'h00);
      cmd(CMD_ERR_ALL_Q);
      chk("520", 1'b1);
      $display("subordinate test done");
   endtask
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      resetn_in = 1'b1;
      repeat (2) @(negedge clk_sys_in);
      eq({7'h00, nv_ind_out}, 8'h01);
      t_fault();
      t_ind();
      t_codes();
      t_over();
      t_clear();
      t_sub();
      // Stored setting returns after reset
      nv_ind_in = 1'b0;
      resetn_in = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      resetn_in = 1'b1;
      repeat (2) @(negedge clk_sys_in);
      eq({7'h00, nv_ind_out}, 8'h00);
      stop_test();
   end
   // Tests take a few thousand cycles
   initial begin
      #200000;
      bad("watchdog expired");
      stop_test();
   end
endmodule
